// File: logic/vrc_pkg.sv
// Package for the video DRAM RAM-port host controller
package vrc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int WORD_ADDR_W = 16;
  localparam int INIT_CYCLES = 8;
  localparam int ROW_COUNT = 256;
  // Times in ns unless noted
  localparam int POWERUP_US = 200;
  localparam int ROW_PRECHARGE_NS = 90;
  localparam int ROW_LOW_NS = 120;
  localparam int ROW_TO_COL_DELAY_NS = 25;
  localparam int COL_LOW_NS = 30;
  localparam int ROW_ACCESS_NS = 120;
  localparam int OUTEN_ACCESS_NS = 30;
  localparam int WRITE_PULSE_NS = 25;
  localparam int COL_PRECHARGE_NS = 20;
  localparam int SC_HALF_NS = 20;
  // Least times round up
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int RP_CYC = (ROW_PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int RAS_CYC = (ROW_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RCD_CYC = (ROW_TO_COL_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int CAS_CYC = (COL_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RAC_CYC = (ROW_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int OEA_CYC = (OUTEN_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CP_CYC = (COL_PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int SC_CYC = (SC_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    VRC_OP_READ,
    VRC_OP_WRITE,
    VRC_OP_MASKED_WRITE,
    VRC_OP_RMW,
    VRC_OP_ROW_REFRESH,
    VRC_OP_CBR_REFRESH
  } vrc_op_t;

  typedef struct packed {
    vrc_op_t               op;
    logic [WORD_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      wdata;
    logic [DATA_W-1:0]      mask;
    logic                   page_next;
  } vrc_req_t;

  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic xfer_outen_n;
    logic maskwr_wren_n;
    logic serial_port_en_n;
    logic serial_shift_clk;
  } vrc_strobe_t;
endpackage : vrc_pkg

// File: logic/vrc_host.sv
// Host controller driving the RAM port of a dual-port video DRAM
`timescale 1ns/1ps
`default_nettype none
module vrc_host
  import vrc_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter bit INIT_WITH_CBR  = 1'b1
) (
  input  wire logic                        CLK_SYS_I,
  input  wire logic                        RST_N_I,
  input  wire vrc_pkg::vrc_req_t           REQ_I,
  input  wire logic                        REQ_VALID_I,
  output logic                             REQ_READY_O,
  output logic [vrc_pkg::DATA_W-1:0]       RDATA_O,
  output logic                             RDATA_VALID_O,
  output logic                             INIT_DONE_O,
  output vrc_pkg::vrc_strobe_t             STROBE_O,
  output logic [vrc_pkg::ADDR_W-1:0]       ADDR_O,
  input  wire logic [vrc_pkg::DATA_W-1:0]  DQ_I,
  output logic [vrc_pkg::DATA_W-1:0]       DQ_O,
  output logic                             DQ_OE_O
);
  import vrc_pkg::*;

  typedef enum logic [3:0] {
    S_POWERUP, S_INIT_SC, S_INIT_RAS, S_IDLE, S_ROW, S_COL,
    S_WRITE, S_OE, S_RMW_WR, S_CAS_HI, S_RAS_HOLD, S_PRECH
  } vrc_state_t;

  vrc_state_t          state;
  vrc_req_t            cur;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    ras_cnt;
  logic [3:0]          init_cnt;
  logic [DATA_W-1:0]   dq_s1;
  logic [DATA_W-1:0]   dq_s2;
  logic [DATA_W-1:0]   dq_s3;
  logic                cnt_zero;
  logic                init_last;

  assign cnt_zero  = (cnt == '0);
  assign init_last = (init_cnt == 4'(INIT_CYCLES - 1));

  // Read data comes from a pin, so it is synchronised first
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
    end else begin
      dq_s1 <= DQ_I;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // Row strobe low-time counter guards the minimum row pulse width
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ras_cnt <= '0;
    end else if (STROBE_O.ras_n) begin
      ras_cnt <= '0;
    end else if (ras_cnt != CNT_W'(RAS_CYC)) begin
      ras_cnt <= ras_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state         <= S_POWERUP;
      cur           <= '0;
      cnt           <= CNT_W'(POWERUP_CYCLES);
      init_cnt      <= '0;
      STROBE_O      <= '1;
      ADDR_O        <= '0;
      DQ_O          <= '0;
      DQ_OE_O       <= 1'b0;
      REQ_READY_O   <= 1'b0;
      RDATA_O       <= '0;
      RDATA_VALID_O <= 1'b0;
      INIT_DONE_O   <= 1'b0;
    end else begin
      RDATA_VALID_O <= 1'b0;
      if (!cnt_zero) begin
        cnt <= cnt - CNT_W'(1);
      end
      unique case (state)
        S_POWERUP: if (cnt_zero) begin
          state <= S_INIT_SC;
          cnt   <= CNT_W'(SC_CYC);
        end
        // Serial clock toggles with output-enable high, 8 full periods
        S_INIT_SC: if (cnt_zero) begin
          STROBE_O.serial_shift_clk <= ~STROBE_O.serial_shift_clk;
          cnt <= CNT_W'(SC_CYC);
          // Count rising edges; the clock idles high so falls alone miss one
          if (!STROBE_O.serial_shift_clk) begin
            if (init_last) begin
              init_cnt <= '0;
              state    <= S_INIT_RAS;
              cnt      <= CNT_W'(RP_CYC);
            end else begin
              init_cnt <= init_cnt + 4'(1);
            end
          end
        end
        S_INIT_RAS: if (cnt_zero) begin
          if (STROBE_O.ras_n && INIT_WITH_CBR && STROBE_O.cas_n) begin
            // Column strobe leads by a cycle, else no counter refresh
            STROBE_O.cas_n <= 1'b0;
          end else if (STROBE_O.ras_n) begin
            STROBE_O.ras_n <= 1'b0;
            cnt <= CNT_W'(RAS_CYC);
          end else begin
            STROBE_O.ras_n <= 1'b1;
            STROBE_O.cas_n <= 1'b1;
            cnt <= CNT_W'(RP_CYC);
            if (init_last) begin
              state       <= S_PRECH;
              INIT_DONE_O <= 1'b1;
            end else begin
              init_cnt <= init_cnt + 4'(1);
            end
          end
        end
        S_IDLE: if (REQ_VALID_I && cnt_zero) begin
          cur         <= REQ_I;
          REQ_READY_O <= 1'b0;
          // Mode levels set up before the row strobe falls
          STROBE_O.xfer_outen_n  <= 1'b1;
          STROBE_O.maskwr_wren_n <= (REQ_I.op != VRC_OP_MASKED_WRITE);
          ADDR_O  <= REQ_I.addr[WORD_ADDR_W-1:ADDR_W];
          DQ_O    <= REQ_I.mask;
          DQ_OE_O <= (REQ_I.op == VRC_OP_MASKED_WRITE);
          STROBE_O.cas_n <= (REQ_I.op != VRC_OP_CBR_REFRESH);
          state   <= S_ROW;
        end
        S_ROW: begin
          STROBE_O.ras_n <= 1'b0;
          cnt   <= CNT_W'(RCD_CYC);
          state <= (cur.op == VRC_OP_ROW_REFRESH ||
                    cur.op == VRC_OP_CBR_REFRESH) ? S_RAS_HOLD : S_COL;
        end
        S_COL: if (cnt_zero) begin
          STROBE_O.maskwr_wren_n <= 1'b1;
          ADDR_O  <= cur.addr[ADDR_W-1:0];
          // Write data valid before column strobe, early write
          DQ_O    <= cur.wdata;
          DQ_OE_O <= (cur.op == VRC_OP_WRITE ||
                      cur.op == VRC_OP_MASKED_WRITE);
          if (cur.op == VRC_OP_WRITE || cur.op == VRC_OP_MASKED_WRITE) begin
            STROBE_O.maskwr_wren_n <= 1'b0;
          end
          state <= S_WRITE;
        end
        S_WRITE: begin
          STROBE_O.cas_n <= 1'b0;
          if (cur.op == VRC_OP_READ || cur.op == VRC_OP_RMW) begin
            STROBE_O.xfer_outen_n <= 1'b0;
            cnt   <= CNT_W'(RAC_CYC > OEA_CYC ? RAC_CYC : OEA_CYC) +
                     CNT_W'(3); // plus synchroniser delay
            state <= S_OE;
          end else begin
            cnt   <= CNT_W'(CAS_CYC > WP_CYC ? CAS_CYC : WP_CYC);
            state <= S_CAS_HI;
          end
        end
        // Data is taken only once the last two sync stages agree
        S_OE: if (cnt_zero && dq_s2 == dq_s3) begin
          RDATA_O       <= dq_s3;
          RDATA_VALID_O <= 1'b1;
          STROBE_O.xfer_outen_n <= 1'b1;
          if (cur.op == VRC_OP_RMW) begin
            // Drive only after output-enable is high again
            DQ_O  <= cur.wdata;
            cnt   <= CNT_W'(OEA_CYC);
            state <= S_RMW_WR;
          end else begin
            state <= S_CAS_HI;
          end
        end
        S_RMW_WR: if (cnt_zero) begin
          if (!DQ_OE_O) begin
            DQ_OE_O <= 1'b1;
            cnt     <= '0;
          end else begin
            STROBE_O.maskwr_wren_n <= 1'b0;
            cnt   <= CNT_W'(WP_CYC);
            state <= S_CAS_HI;
          end
        end
        S_CAS_HI: if (cnt_zero) begin
          STROBE_O.cas_n         <= 1'b1;
          STROBE_O.maskwr_wren_n <= 1'b1;
          DQ_OE_O <= 1'b0;
          // Page mode keeps the row open for another column
          if (cur.page_next && REQ_VALID_I && REQ_I.page_next &&
              (REQ_I.addr[WORD_ADDR_W-1:ADDR_W] ==
               cur.addr[WORD_ADDR_W-1:ADDR_W]) &&
              (REQ_I.op == VRC_OP_READ || REQ_I.op == VRC_OP_WRITE ||
               REQ_I.op == VRC_OP_RMW)) begin
            cur   <= REQ_I;
            cnt   <= CNT_W'(CP_CYC);
            state <= S_COL;
          end else begin
            state <= S_RAS_HOLD;
          end
        end
        // Row strobe rises only after its minimum low width
        S_RAS_HOLD: if (ras_cnt == CNT_W'(RAS_CYC) && cnt_zero) begin
          STROBE_O.ras_n <= 1'b1;
          STROBE_O.cas_n <= 1'b1; // mask ends with the cycle
          cnt         <= CNT_W'(RP_CYC);
          DQ_OE_O     <= 1'b0;
          state       <= S_PRECH;
        end
        // Ready rises as precharge ends, so a seen ready is always taken
        S_PRECH: if (cnt <= CNT_W'(1)) begin
          REQ_READY_O <= 1'b1;
          state       <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule : vrc_host
`default_nettype wire

// File: verif/vrc_host_props.sv
// Checker on the pins of the video DRAM host controller
`timescale 1ns/1ps
`default_nettype none
module vrc_host_props
  import vrc_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter bit INIT_WITH_CBR  = 1'b1
) (
  input wire logic                         CLK_SYS_I,
  input wire logic                         RST_N_I,
  input wire logic                         INIT_DONE_O,
  input wire vrc_pkg::vrc_strobe_t         STROBE_O,
  input wire logic [vrc_pkg::ADDR_W-1:0]   ADDR_O,
  input wire logic                         DQ_OE_O
);
  vrc_strobe_t s;
  logic [15:0] cyc, lo, hi, nr, ns;
  assign s = STROBE_O;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  // cyc and hi saturate so a long idle gap never wraps back under the limit
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cyc <= '0;
      lo <= '0;
      hi <= '0;
      nr <= '0;
      ns <= '0;
    end else begin
      cyc <= cyc + 16'(cyc != '1);
      lo <= s.ras_n ? '0 : lo + 16'd1;
      hi <= s.ras_n ? hi + 16'(hi != '1) : '0;
      nr <= nr + 16'($fell(s.ras_n));
      ns <= ns + 16'($fell(s.serial_shift_clk));
    end
  end
  sequence row_fall; $fell(s.ras_n) && s.cas_n; endsequence
  sequence col_fall; $fell(s.cas_n) && !s.ras_n; endsequence
  row_addr_a: assert property (row_fall |-> $stable(ADDR_O))
    else $error("row address moved at row strobe fall");
  col_addr_a: assert property (col_fall |-> $stable(ADDR_O))
    else $error("column address moved at column strobe fall");
  precharge_a: assert property ($fell(s.ras_n) |-> hi >= RP_CYC)
    else $error("row strobe precharge too short");
  ras_width_a: assert property ($rose(s.ras_n) |-> lo >= RAS_CYC)
    else $error("row strobe low too short");
  oe_width_a: assert property ($fell(s.xfer_outen_n) |=>
    !s.xfer_outen_n[*2]) else $error("output enable low too short");
  oe_clash_a: assert property (!s.xfer_outen_n |->
    s.maskwr_wren_n && !DQ_OE_O) else $error("write during output");
  wdata_a: assert property (($fell(s.cas_n) ||
    $fell(s.maskwr_wren_n)) && !s.cas_n && !s.maskwr_wren_n && !s.ras_n
    |-> DQ_OE_O) else $error("write data not driven");
  oe_row_a: assert property ($fell(s.ras_n) |->
    s.xfer_outen_n && $past(s.xfer_outen_n)) else $error("oe low at row");
  powerup_a: assert property (cyc < POWERUP_CYCLES |->
    s.ras_n && $stable(s.serial_shift_clk)) else $error("no power-up wait");
  init_cnt_a: assert property ($rose(INIT_DONE_O) |->
    nr >= INIT_CYCLES && ns >= INIT_CYCLES) else $error("short init");
  init_cbr_a: assert property (!INIT_DONE_O && $fell(s.ras_n) |->
    !s.cas_n || !INIT_WITH_CBR) else $error("init cycle not refresh");
endmodule : vrc_host_props
bind vrc_host vrc_host_props #(
  .POWERUP_CYCLES(POWERUP_CYCLES),
  .INIT_WITH_CBR (INIT_WITH_CBR)
) vrc_host_props_inst (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .INIT_DONE_O(INIT_DONE_O),
  .STROBE_O(STROBE_O), .ADDR_O(ADDR_O), .DQ_OE_O(DQ_OE_O)
);
`default_nettype wire

// File: verif/vrc_dram_model.sv
// Behavioural model of the video DRAM RAM port
`timescale 1ns/1ps
`default_nettype none
module vrc_dram_model
  import vrc_pkg::*;
(
  input  wire vrc_pkg::vrc_strobe_t         st_i,
  input  wire logic [vrc_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [vrc_pkg::DATA_W-1:0]   dq_i,
  output logic [vrc_pkg::DATA_W-1:0]        dq_o,
  output logic                              dq_oe_o
);
  logic [DATA_W-1:0] mem [0:65535];
  logic [7:0]        row, rcnt;
  logic [15:0]       wa;
  logic [DATA_W-1:0] wm;
  logic              rd_ok;
  initial begin
    foreach (mem[i]) mem[i] = '0;
    {row, rcnt, wa, wm, rd_ok} = '0;
  end
  task automatic write_word();
    mem[wa] = (mem[wa] & ~wm) | (dq_i & wm);
  endtask : write_word
  always @(negedge st_i.ras_n) begin
    row = st_i.cas_n ? addr_i : rcnt;
    if (!st_i.cas_n) rcnt = rcnt + 8'd1;
    wm = st_i.maskwr_wren_n ? '1 : dq_i;
  end
  // Mask dies with its cycle
  always @(posedge st_i.ras_n) wm = '1;
  // Writes only with row strobe low, so idle never touches the array
  always @(negedge st_i.cas_n) begin
    wa = {row, addr_i};
    rd_ok = st_i.maskwr_wren_n;
    if (!st_i.ras_n && !st_i.maskwr_wren_n) write_word();
  end
  always @(negedge st_i.maskwr_wren_n) begin
    if (!st_i.ras_n && !st_i.cas_n) write_word();
  end
  assign dq_o = mem[wa];
  assign dq_oe_o = !st_i.cas_n && !st_i.xfer_outen_n && rd_ok;
endmodule : vrc_dram_model
`default_nettype wire

// File: verif/vrc_host_tb.sv
// Self-checking bench for the video DRAM host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module vrc_host_tb;
  import vrc_pkg::*;
  logic              clk, rst_n, vld, rdy, rv, done, dq_oe, dev_oe;
  vrc_req_t          req;
  vrc_strobe_t       st;
  logic [DATA_W-1:0] rdata, dq_o, dq_w, dev_dq, flt;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] exp_m [0:65535];
  logic [31:0]       r;
  int                err_total, checks_done;
  // Released pins drift instead of holding the last value
  assign dq_w = dq_oe ? dq_o : dev_oe ? dev_dq : flt;
  always @(posedge clk) flt <= ~dq_w;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  vrc_host #(.POWERUP_CYCLES(20), .INIT_WITH_CBR(1'b1)) vrc_host_inst (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .REQ_I(req), .REQ_VALID_I(vld),
    .REQ_READY_O(rdy), .RDATA_O(rdata), .RDATA_VALID_O(rv),
    .INIT_DONE_O(done), .STROBE_O(st), .ADDR_O(addr), .DQ_I(dq_w),
    .DQ_O(dq_o), .DQ_OE_O(dq_oe));
  vrc_dram_model vrc_dram_model_inst (.st_i(st), .addr_i(addr),
    .dq_i(dq_w), .dq_o(dev_dq), .dq_oe_o(dev_oe));
  function automatic logic [3:0] merge(input logic [3:0] o, d, m);
    return (o & ~m) | (d & m);
  endfunction : merge
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic take(input vrc_req_t q);
    @(posedge clk) #1;
    req = q;
    vld = 1'b1;
    for (int i = 0; i < 200 && rdy !== 1'b1; i++) @(posedge clk) #1;
    `CHK(rdy, 1'b1)
    @(posedge clk) #1;
  endtask : take
  task automatic get_read(input logic [3:0] e);
    for (int i = 0; i < 80 && rv !== 1'b1; i++) @(posedge clk) #1;
    `CHK(rv, 1'b1)
    `CHK(rdata, e)
  endtask : get_read
  task automatic run(input vrc_op_t op, input logic [15:0] a,
                     input logic [3:0] d, m);
    logic [3:0] old;
    old = exp_m[a];
    take('{op, a, d, m, 1'b0});
    vld = 1'b0;
    if (op == VRC_OP_WRITE || op == VRC_OP_RMW) exp_m[a] = d;
    if (op == VRC_OP_MASKED_WRITE) exp_m[a] = merge(old, d, m);
    if (op == VRC_OP_READ || op == VRC_OP_RMW) get_read(old);
  endtask : run
  task automatic page(input logic [15:0] a, input logic [3:0] d);
    take('{VRC_OP_WRITE, a, d, 4'h0, 1'b1});
    req = '{VRC_OP_READ, a, 4'h0, 4'h0, 1'b1};
    @(posedge st.cas_n);
    @(posedge clk) #1;
    vld = 1'b0;
    exp_m[a] = d;
    get_read(d);
  endtask : page
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    logic [15:0] a;
    {rst_n, vld, req, flt} = '0;
    foreach (exp_m[k]) exp_m[k] = '0;
    r = $urandom(32'h096d);
    repeat (3) @(posedge clk);
    #1;
    `CHK(st, 6'h3F)
    `CHK(dq_oe, 1'b0)
    rst_n = 1'b1;
    for (int i = 0; i < 2000 && done !== 1'b1; i++) @(posedge clk) #1;
    `CHK(done, 1'b1)
    run(VRC_OP_MASKED_WRITE, 16'h1234, 4'hF, 4'h0);
    run(VRC_OP_READ, 16'h1234, 4'h0, 4'h0);
    run(VRC_OP_WRITE, 16'h1234, 4'hA, 4'h0);
    run(VRC_OP_MASKED_WRITE, 16'h1234, 4'h5, 4'h6);
    run(VRC_OP_WRITE, 16'h1235, 4'h3, 4'h0);
    run(VRC_OP_RMW, 16'h1234, 4'hC, 4'h0);
    run(VRC_OP_READ, 16'h1235, 4'h0, 4'h0);
    page(16'h2211, 4'h9);
    // Small address pool so reads land on earlier writes and refreshes
    for (int i = 0; i < 60; i++) begin
      r = $urandom();
      a = 16'h8142 ^ (r[15:0] & 16'h0303);
      run(vrc_op_t'(3'(r[18:16] % 3'd6)), a, r[23:20], r[27:24]);
    end
    print_verdict();
  end
endmodule : vrc_host_tb
`default_nettype wire
